/* core/trm_device.sv */
`timescale 1ns/100ps
// How it works
// - trim starts after long low then high
// - short low or high intervals are ignored
// - pin ORed with bit 15 under extended_control
// - host lowers pin and bit between trims
// - trim_running high for whole trim
// - same procedure whatever started the trim
// - power-on trim after selected delay
// - delay select toggle may start trim
// - request high at power-on skips power-on trim
// - host holds request high around select change; trm_host changes the select pin without raising request
// - host issues trim after blocked power-on
// - host fixes delay select before power
// - trim adjust register at address 4h
// - host runs one trim before relying
// - data low during trim, 60 cycles settle
// - both channels down pauses the trim
// - bit 14 picks sequence, default resistor too
// - duration field value 11b never used
module trm_device
  import trm_pkg::*;
#(
  parameter int MIN_LOW = TRM_REQ_LOW_MIN,
  parameter int MIN_HIGH = TRM_REQ_HIGH_MIN,
  parameter int PU_SHORT = TRM_PU_SHORT,
  parameter int PU_LONG = TRM_PU_LONG,
  parameter int RES_CYCLES = TRM_RES_CYCLES,
  parameter int LIN0_CYCLES = TRM_LIN0_CYCLES,
  parameter int LIN1_CYCLES = TRM_LIN1_CYCLES,
  parameter int LIN2_CYCLES = TRM_LIN2_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  trm_link_if.dev link,
  output logic data_valid,
  output logic powered_down,
  output logic trim_count_odd,
  output logic resistor_trimmed
);

  // ****************************************
  // declarations
  // ****************************************
  localparam int CW = 32;

  trm_state_e state_reg;
  logic [15:0] cfg_reg;
  logic [15:0] adj_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] run_len;
  logic [CW-1:0] pu_len;
  logic strap_taken_reg;
  logic skip_reg;
  logic dsel_prev_reg;
  logic eff_req;
  logic fire;
  logic toggle;
  logic both_down;
  logic start;
  logic run_end;
  logic settle_end;
  logic pu_end;

  // ****************************************
  // trim length from adjust fields
  // ****************************************
  function automatic logic [CW-1:0] trm_run_len(input logic [15:0] adj);
    logic [CW-1:0] lin;
    lin = CW'(LIN0_CYCLES);
    case (adj[TRM_DUR_LSB +: 2])
      2'h1: lin = CW'(LIN1_CYCLES);
      2'h2: lin = CW'(LIN2_CYCLES);
      default: lin = CW'(LIN0_CYCLES);
    endcase
    if (adj[TRM_SEQ_BIT]) begin
      lin = lin + CW'(RES_CYCLES);
    end
    return lin;
  endfunction : trm_run_len

  assign run_len = trm_run_len(adj_reg);
  assign pu_len = link.powerup_trim_delay_select ? CW'(PU_LONG) : CW'(PU_SHORT);
  assign eff_req = link.trim_request | (link.extended_control & cfg_reg[TRM_REQ_BIT]);
  assign toggle = strap_taken_reg && (link.powerup_trim_delay_select != dsel_prev_reg);
  assign both_down = link.i_channel_powerdown & link.q_channel_powerdown;
  assign start = fire | toggle;
  assign run_end = (state_reg == TRM_RUN) && !both_down && (cnt_reg >= run_len - 1'b1);
  assign settle_end = (state_reg == TRM_SETTLE) && (cnt_reg == CW'(TRM_SETTLE_CYCLES - 1));
  assign pu_end = (state_reg == TRM_POWERUP) && strap_taken_reg && !skip_reg && !eff_req &&
                  (cnt_reg >= pu_len - 1'b1);

  // ****************************************
  // request filter
  // ****************************************
  trm_req_filter #(
    .MIN_LOW(MIN_LOW),
    .MIN_HIGH(MIN_HIGH)
  ) u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(eff_req),
    .fire(fire)
  );

  // ****************************************
  // power-on strap
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_taken_reg <= 1'b0;
      skip_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      skip_reg <= link.trim_request;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dsel_prev_reg <= 1'b0;
    end else begin
      dsel_prev_reg <= link.powerup_trim_delay_select;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= TRM_POWERUP;
    end else begin
      case (state_reg)
        TRM_POWERUP: begin
          if (strap_taken_reg && (skip_reg || eff_req)) begin
            state_reg <= TRM_IDLE;
          end else if (pu_end) begin
            state_reg <= TRM_RUN;
          end
        end
        TRM_IDLE: begin
          if (start) begin
            state_reg <= TRM_RUN;
          end
        end
        TRM_RUN: begin
          if (run_end) begin
            state_reg <= TRM_SETTLE;
          end
        end
        TRM_SETTLE: begin
          if (start) begin
            state_reg <= TRM_RUN;
          end else if (settle_end) begin
            state_reg <= TRM_IDLE;
          end
        end
        default: state_reg <= TRM_IDLE;
      endcase
    end
  end

  // shared cycle counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        TRM_POWERUP: begin
          if (toggle || !strap_taken_reg) begin
            cnt_reg <= '0;
          end else if (!pu_end) begin
            cnt_reg <= cnt_reg + 1'b1;
          end else begin
            cnt_reg <= '0;
          end
        end
        TRM_RUN: begin
          if (run_end) begin
            cnt_reg <= '0;
          end else if (!both_down) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        TRM_SETTLE: begin
          if (start || settle_end) begin
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: cnt_reg <= '0;
      endcase
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.trim_running <= 1'b0;
    end else if (run_end) begin
      link.trim_running <= 1'b0;
    end else if (pu_end || ((state_reg == TRM_IDLE || state_reg == TRM_SETTLE) && start)) begin
      link.trim_running <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_valid <= 1'b1;
    end else begin
      data_valid <= (state_reg == TRM_IDLE && !start) || (state_reg == TRM_POWERUP && !pu_end) ||
                    (settle_end && !start);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      powered_down <= 1'b0;
    end else begin
      powered_down <= both_down;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_count_odd <= 1'b0;
    end else if (run_end) begin
      trim_count_odd <= ~trim_count_odd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resistor_trimmed <= 1'b0;
    end else if (run_end && adj_reg[TRM_SEQ_BIT]) begin
      resistor_trimmed <= 1'b1;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= TRM_CFG_RESET;
    end else if (link.reg_wr && link.reg_addr == TRM_CFG_ADDR) begin
      cfg_reg <= link.reg_wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adj_reg <= TRM_ADJ_RESET;
    end else if (link.reg_wr && link.reg_addr == TRM_ADJ_ADDR) begin
      adj_reg <= link.reg_wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.reg_rdata <= '0;
    end else if (link.reg_addr == TRM_CFG_ADDR) begin
      link.reg_rdata <= cfg_reg;
    end else if (link.reg_addr == TRM_ADJ_ADDR) begin
      link.reg_rdata <= adj_reg;
    end else begin
      link.reg_rdata <= '0;
    end
  end

endmodule : trm_device

/* core/trm_host.sv */
`timescale 1ns/100ps
module trm_host
  import trm_pkg::*;
#(
  parameter int MIN_LOW = TRM_REQ_LOW_MIN,
  parameter int MIN_HIGH = TRM_REQ_HIGH_MIN,
  parameter int PU_HOLD = TRM_PU_HOLD,
  parameter bit BLOCK_POWERUP = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  trm_link_if.host link
);

  // ****************************************
  // declarations
  // ****************************************
  trm_hstate_e st_reg;
  logic [31:0] cnt_reg;
  logic [31:0] hold_cnt_reg;
  logic hold_reg;
  logic [5:0] ctrl_reg;
  logic done_reg;
  logic run_prev_reg;
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic take;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_dev;
  logic go;

  assign take = hsel && hready && (htrans == TRM_HTRANS_NONSEQ);
  assign wr_ctrl = wr_pend_reg && addr_reg == TRM_H_CTRL_OFS;
  assign wr_stat = wr_pend_reg && addr_reg == TRM_H_STAT_OFS;
  assign wr_dev = wr_pend_reg && addr_reg == TRM_H_DEV_OFS;
  assign go = wr_ctrl && hwdata[TRM_C_START] && st_reg == TRM_H_IDLE;

  // ****************************************
  // bus slave
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= '0;
    end else begin
      wr_pend_reg <= take && hwrite;
      addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (take && !hwrite) begin
      if (haddr[7:0] == TRM_H_CTRL_OFS) begin
        hrdata <= {26'h0, ctrl_reg[5:1], 1'b0};
      end else if (haddr[7:0] == TRM_H_STAT_OFS) begin
        hrdata <= {link.reg_rdata, 12'h0, done_reg, hold_reg, link.trim_running, st_reg != TRM_H_IDLE};
      end else begin
        hrdata <= '0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= TRM_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= {hwdata[5:1], 1'b0};
    end
  end

  // done flag, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_prev_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      run_prev_reg <= link.trim_running;
      if (run_prev_reg && !link.trim_running) begin
        done_reg <= 1'b1;
      end else if (wr_stat && hwdata[TRM_S_DONE]) begin
        done_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // device register access
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.reg_wr <= 1'b0;
      link.reg_addr <= '0;
      link.reg_wdata <= '0;
    end else begin
      link.reg_wr <= wr_dev;
      if (wr_dev) begin
        link.reg_addr <= hwdata[19:16];
        link.reg_wdata <= (hwdata[19:16] == TRM_ADJ_ADDR && hwdata[1:0] == TRM_DUR_BAD) ?
                          {hwdata[15:2], 2'h0} : hwdata[15:0];
      end
    end
  end

  // ****************************************
  // request sequencer
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_reg <= BLOCK_POWERUP;
      hold_cnt_reg <= '0;
    end else if (hold_reg) begin
      if (hold_cnt_reg == 32'(PU_HOLD - 1)) begin
        hold_reg <= 1'b0;
      end else begin
        hold_cnt_reg <= hold_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= TRM_H_IDLE;
      cnt_reg <= '0;
    end else begin
      case (st_reg)
        TRM_H_IDLE: begin
          cnt_reg <= '0;
          if (go) begin
            st_reg <= TRM_H_LOW;
          end
        end
        TRM_H_LOW: begin
          if (cnt_reg == 32'(MIN_LOW)) begin
            st_reg <= TRM_H_HIGH;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        TRM_H_HIGH: begin
          if (cnt_reg == 32'(MIN_HIGH)) begin
            st_reg <= TRM_H_IDLE;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: st_reg <= TRM_H_IDLE;
      endcase
    end
  end

  // ****************************************
  // pins
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.trim_request <= BLOCK_POWERUP;
      link.powerup_trim_delay_select <= 1'b0;
      link.extended_control <= 1'b0;
      link.i_channel_powerdown <= 1'b0;
      link.q_channel_powerdown <= 1'b0;
    end else begin
      link.trim_request <= hold_reg || ctrl_reg[TRM_C_FORCE] ||
                           (st_reg == TRM_H_HIGH && cnt_reg != 32'(MIN_HIGH));
      link.powerup_trim_delay_select <= ctrl_reg[TRM_C_DSEL];
      link.extended_control <= ctrl_reg[TRM_C_ECM];
      link.i_channel_powerdown <= ctrl_reg[TRM_C_PDI];
      link.q_channel_powerdown <= ctrl_reg[TRM_C_PDQ];
    end
  end

endmodule : trm_host

/* core/trm_link_if.sv */
`timescale 1ns/100ps
interface trm_link_if;
  logic trim_request;
  logic powerup_trim_delay_select;
  logic extended_control;
  logic i_channel_powerdown;
  logic q_channel_powerdown;
  logic trim_running;
  logic reg_wr;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;

  modport dev (
    input trim_request,
    input powerup_trim_delay_select,
    input extended_control,
    input i_channel_powerdown,
    input q_channel_powerdown,
    output trim_running,
    input reg_wr,
    input reg_addr,
    input reg_wdata,
    output reg_rdata
  );

  modport host (
    output trim_request,
    output powerup_trim_delay_select,
    output extended_control,
    output i_channel_powerdown,
    output q_channel_powerdown,
    input trim_running,
    output reg_wr,
    output reg_addr,
    output reg_wdata,
    input reg_rdata
  );
endinterface : trm_link_if

/* core/trm_pkg.sv */
package trm_pkg;

  // ****************************************
  // device register map
  // ****************************************
  localparam logic [3:0] TRM_CFG_ADDR = 4'h0;
  localparam logic [3:0] TRM_ADJ_ADDR = 4'h4;
  localparam int TRM_REQ_BIT = 15;
  localparam int TRM_SEQ_BIT = 14;
  localparam int TRM_DUR_LSB = 0;
  localparam logic [15:0] TRM_CFG_RESET = 16'h0000;
  localparam logic [15:0] TRM_ADJ_RESET = 16'h4000;
  localparam logic [1:0] TRM_DUR_BAD = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int TRM_CLK_PERIOD_PS = 5000;
  localparam int TRM_SETTLE_CYCLES = 60;
  localparam int TRM_REQ_LOW_MIN = 16;
  localparam int TRM_REQ_HIGH_MIN = 16;
  localparam int TRM_PU_SHORT = 16384;
  localparam int TRM_PU_LONG = 65536;
  localparam int TRM_RES_CYCLES = 1024;
  localparam int TRM_LIN0_CYCLES = 4096;
  localparam int TRM_LIN1_CYCLES = 2048;
  localparam int TRM_LIN2_CYCLES = 1024;
  localparam int TRM_PU_HOLD = 1000000000;

  // ****************************************
  // controller register map
  // ****************************************
  localparam logic [7:0] TRM_H_CTRL_OFS = 8'h00;
  localparam logic [7:0] TRM_H_STAT_OFS = 8'h04;
  localparam logic [7:0] TRM_H_DEV_OFS = 8'h08;
  localparam int TRM_C_START = 0;
  localparam int TRM_C_FORCE = 1;
  localparam int TRM_C_DSEL = 2;
  localparam int TRM_C_ECM = 3;
  localparam int TRM_C_PDI = 4;
  localparam int TRM_C_PDQ = 5;
  localparam int TRM_S_BUSY = 0;
  localparam int TRM_S_RUN = 1;
  localparam int TRM_S_HOLD = 2;
  localparam int TRM_S_DONE = 3;
  localparam logic [5:0] TRM_CTRL_RESET = 6'h00;
  localparam logic [1:0] TRM_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {TRM_POWERUP, TRM_IDLE, TRM_RUN, TRM_SETTLE} trm_state_e;
  typedef enum logic [1:0] {TRM_H_IDLE, TRM_H_LOW, TRM_H_HIGH} trm_hstate_e;

endpackage : trm_pkg

/* core/trm_req_filter.sv */
`timescale 1ns/100ps
module trm_req_filter
  import trm_pkg::*;
#(
  parameter int MIN_LOW = TRM_REQ_LOW_MIN,
  parameter int MIN_HIGH = TRM_REQ_HIGH_MIN
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req,
  output logic fire
);
  localparam int LW = $clog2(MIN_LOW + 1);
  localparam int HW = $clog2(MIN_HIGH + 1);
  localparam logic [LW-1:0] LOW_LAST = LW'(MIN_LOW - 1);
  localparam logic [HW-1:0] HIGH_LAST = HW'(MIN_HIGH - 1);

  logic [LW-1:0] low_cnt_reg;
  logic [HW-1:0] high_cnt_reg;
  logic armed_reg;
  logic hit;

  assign hit = req && armed_reg && (high_cnt_reg == HIGH_LAST);

  // consecutive low cycles, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_reg <= '0;
    end else if (req) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != LOW_LAST) begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end
  end

  // armed only after a full low interval
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_reg <= 1'b0;
    end else if (!req) begin
      armed_reg <= (low_cnt_reg == LOW_LAST);
    end else if (hit) begin
      armed_reg <= 1'b0;
    end
  end

  // consecutive high cycles after arming
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_cnt_reg <= '0;
    end else if (!req || !armed_reg || hit) begin
      high_cnt_reg <= '0;
    end else begin
      high_cnt_reg <= high_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fire <= 1'b0;
    end else begin
      fire <= hit;
    end
  end
endmodule : trm_req_filter

/* sim/test_converter_trim_sequencer.sv */
`timescale 1ns/100ps
module test_converter_trim_sequencer;
  import trm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, dv, dv_pu, pdn, odd, rtrim;
  logic [31:0] hrdata;
  logic rd_pend = 1'b0;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int run_cnt = 0;
  int runs = 0;
  logic [31:0] exp_rd[$];
  logic [31:0] msk_rd[$];
  int exp_run[$];
  trm_link_if link();
  trm_link_if link_pu();
  always #2.5 hclk = ~hclk;
  // ****
  // design pairs and checker
  // ****
  localparam int MN = 4, PS = 40, PL = 80, RS = 20, L0 = 40, L1 = 30, L2 = 20, PH = 50;
  trm_device #(.MIN_LOW(MN), .MIN_HIGH(MN), .PU_SHORT(PS), .PU_LONG(PL), .RES_CYCLES(RS), .LIN0_CYCLES(L0),
    .LIN1_CYCLES(L1), .LIN2_CYCLES(L2)) trm_device_i (.hclk(hclk), .hresetn(hresetn), .link(link),
    .data_valid(dv), .powered_down(pdn), .trim_count_odd(odd), .resistor_trimmed(rtrim));
  trm_host #(.MIN_LOW(MN), .MIN_HIGH(MN), .PU_HOLD(PH), .BLOCK_POWERUP(1'b1)) trm_host_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
  trm_device #(.MIN_LOW(MN), .MIN_HIGH(MN), .PU_SHORT(PS), .PU_LONG(PL), .RES_CYCLES(RS), .LIN0_CYCLES(L0),
    .LIN1_CYCLES(L1), .LIN2_CYCLES(L2)) trm_device_pu_i (.hclk(hclk), .hresetn(hresetn), .link(link_pu),
    .data_valid(dv_pu), .powered_down(), .trim_count_odd(), .resistor_trimmed());
  trm_host #(.MIN_LOW(MN), .MIN_HIGH(MN), .PU_HOLD(PH)) trm_host_pu_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(1'b0), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(), .link(link_pu));
  trm_checker #(.MAX_RUN(L0 + RS), .PU_MIN(PS)) trm_checker_i (.hclk(hclk), .hresetn(hresetn),
    .trim_request(link.trim_request), .powerup_trim_delay_select(link.powerup_trim_delay_select),
    .extended_control(link.extended_control), .i_channel_powerdown(link.i_channel_powerdown),
    .q_channel_powerdown(link.q_channel_powerdown), .trim_running(link.trim_running), .reg_wr(link.reg_wr),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata));
  // ****
  // tasks and monitor
  // ****
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= TRM_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : ahb
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_rd.push_back(e & m);
    msk_rd.push_back(m);
    ahb(1'b0, a, 32'h0);
  endtask : rd
  task dev_wr(input logic [3:0] a, input logic [15:0] d);
    ahb(1'b1, TRM_H_DEV_OFS, {12'h0, a, d});
  endtask : dev_wr
  task dev_rw(input logic [3:0] a, input logic [15:0] d, input logic [15:0] e, input logic [15:0] m);
    dev_wr(a, d);
    repeat (3) @(posedge hclk);
    rd(TRM_H_STAT_OFS, {e, 16'h0}, {m, 16'h0});
  endtask : dev_rw
  task trim_wait(input int lim);
    int n;
    n = 0;
    while (link.trim_running !== 1'b1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
    check(n < lim, 1'b1);
    repeat (2) @(posedge hclk);
    check(dv, 1'b0);
    while (link.trim_running !== 1'b0 && n < 1000) begin
      @(posedge hclk);
      n++;
    end
    n = 0;
    while (dv !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    check(n, 60);
  endtask : trim_wait
  function automatic int len(input logic s, input logic [1:0] d);
    return (d == 2'h1 ? 30 : d == 2'h2 ? 20 : 40) + (s ? 20 : 0);
  endfunction : len
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      test_done();
    end
    if (rd_pend && hreadyout === 1'b1) check(hrdata & msk_rd.pop_front(), exp_rd.pop_front());
    if (rd_pend && hreadyout === 1'b1) check(hresp, 1'b0);
    if (hreadyout === 1'b1) rd_pend = hsel && htrans == TRM_HTRANS_NONSEQ && !hwrite;
    if (link.trim_running === 1'b1) begin
      if (!(link.i_channel_powerdown && link.q_channel_powerdown)) run_cnt++;
    end else if (run_cnt != 0) begin
      check(run_cnt, exp_run.pop_front());
      run_cnt = 0;
      runs++;
    end
  end
  initial begin
    int n;
    logic [1:0] d;
    void'($urandom(32'h0fe7));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    n = 0;
    while (link_pu.trim_running !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    check(n >= 39 && n <= 44, 1'b1);
    n = 0;
    while (link_pu.trim_running === 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    check(n, 60);
    repeat (70) @(posedge hclk);
    check(dv_pu, 1'b1);
    check(link.trim_running, 1'b0);
    check(dv, 1'b1);
    $display("end power-on");
    rd(8'h0c, 32'h0, 32'hffffffff);
    dev_rw(4'h4, 16'h4003, 16'h4000, 16'h4003);
    dev_rw(4'h6, 16'hffff, 16'h0000, 16'hffff);
    d = 2'($urandom % 3);
    dev_rw(4'h4, {14'h0, d}, {14'h0, d}, 16'h4003);
    $display("end registers");
    for (int i = 0; i < 6; i++) begin
      d = 2'(i / 2);
      dev_wr(4'h4, {1'b0, ~i[0], 12'h0, d});
      exp_run.push_back(len(~i[0], d));
      ahb(1'b1, TRM_H_CTRL_OFS, 32'h1);
      trim_wait(200);
    end
    check(rtrim, 1'b1);
    check(odd, runs[0]);
    $display("end on-command");
    ahb(1'b1, TRM_H_CTRL_OFS, 32'h8);
    dev_wr(4'h0, 16'h0000);
    repeat (8) @(posedge hclk);
    exp_run.push_back(len(1'b0, 2'h2));
    dev_wr(4'h0, 16'h8000);
    trim_wait(50);
    dev_wr(4'h0, 16'h0000);
    repeat (8) @(posedge hclk);
    dev_wr(4'h0, 16'h8000);
    dev_wr(4'h0, 16'h0000);
    repeat (30) @(posedge hclk);
    check(runs, 7);
    $display("end request filter");
    exp_run.push_back(len(1'b0, 2'h2));
    ahb(1'b1, TRM_H_CTRL_OFS, 32'hc);
    trim_wait(300);
    exp_run.push_back(len(1'b0, 2'h2));
    ahb(1'b1, TRM_H_CTRL_OFS, 32'hd);
    n = 0;
    while (link.trim_running !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    ahb(1'b1, TRM_H_CTRL_OFS, 32'h3c);
    repeat (10) @(posedge hclk);
    check(pdn, 1'b1);
    check(link.trim_running, 1'b1);
    ahb(1'b1, TRM_H_CTRL_OFS, 32'hc);
    trim_wait(5);
    $display("end powerdown pause");
    test_done();
  end
endmodule : test_converter_trim_sequencer

/* sim/trm_checker.sv */
`timescale 1ns/100ps
module trm_checker #(
  parameter int MAX_RUN = 60,
  parameter int PU_MIN = 40
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic trim_request,
  input wire logic powerup_trim_delay_select,
  input wire logic extended_control,
  input wire logic i_channel_powerdown,
  input wire logic q_channel_powerdown,
  input wire logic trim_running,
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  // ****
  // effective request and counters
  // ****
  logic cfg_req_reg;
  logic seen_reg;
  logic strap_reg;
  int since_reg;
  int run_reg;
  logic eff;
  logic late;
  logic both_pd;
  assign eff = trim_request | (extended_control & cfg_req_reg);
  assign late = since_reg >= 200;
  assign both_pd = i_channel_powerdown & q_channel_powerdown;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cfg_req_reg <= 1'b0;
    else if (reg_wr && reg_addr == 4'h0) cfg_req_reg <= reg_wdata[15];
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) since_reg <= 0;
    else if (!late) since_reg <= since_reg + 1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_reg <= 1'b0;
      strap_reg <= 1'b0;
    end else begin
      seen_reg <= 1'b1;
      if (!seen_reg) strap_reg <= trim_request;
      else if (!trim_request) strap_reg <= 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) run_reg <= 0;
    else if (!trim_running) run_reg <= 0;
    else if (!both_pd) run_reg <= run_reg + 1;
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_req;
    (!eff)[*5] ##1 eff[*4];
  endsequence
  a_req_start: assert property (s_req ##0 (late && !trim_running) |=> !trim_running ##1 trim_running)
    else $error("trim not started after valid request");
  a_short_ignored: assert property ((!eff)[*5] ##1 eff[*3] ##1 (!eff && !trim_running) |=> (!trim_running)[*4])
    else $error("trim started by short request");
  a_run_min: assert property ($rose(trim_running) |=> trim_running[*8])
    else $error("trim ended too early");
  a_run_max: assert property (run_reg <= MAX_RUN + 1)
    else $error("trim ran too long");
  a_pd_pause: assert property ((trim_running && both_pd)[*2] |=> trim_running)
    else $error("trim ended while powered down");
  a_strap_skip: assert property (strap_reg |-> !trim_running)
    else $error("power-on trim not skipped");
  a_no_early: assert property (since_reg < PU_MIN |-> !trim_running)
    else $error("trim before power-up delay");
  a_adj_readback: assert property ((reg_wr && reg_addr == 4'h4) ##1 (reg_addr == 4'h4)
    |=> reg_rdata[14] == $past(reg_wdata[14], 2) && reg_rdata[1:0] == $past(reg_wdata[1:0], 2))
    else $error("trim adjust readback wrong");
  a_unmapped_zero: assert property (reg_addr != 4'h0 && reg_addr != 4'h4 |=> reg_rdata == 16'h0000)
    else $error("unmapped device read not zero");
  c_run: cover property ($rose(trim_running));
  c_pause: cover property (trim_running && both_pd);
  c_adj: cover property (reg_wr && reg_addr == 4'h4);
endmodule : trm_checker
